// ===== dcf_fifo.sv
// nine-bit first-in first-out buffer with fixed and programmable flags
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps

module dcf_fifo #(
    parameter int DEPTH = dcf_pkg::DCF_DEPTH_DEF
) (
    // clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // fifo control pins
    input wire logic fifo_reset_n_i,
    input wire logic write_enable_primary_n_i,
    input wire logic write_enable_second_or_load_i,
    input wire logic read_enable_a_n_i,
    input wire logic read_enable_b_n_i,
    // data
    input wire logic [dcf_pkg::DCF_DATA_W-1:0] write_data_i,
    output logic [dcf_pkg::DCF_DATA_W-1:0] read_data_o,
    // flags, active low
    output logic full_flag_n_o,
    output logic empty_flag_n_o,
    output logic almost_full_flag_n_o,
    output logic almost_empty_flag_n_o,
    // status
    output logic dual_enable_mode_o,
    output logic write_refused_o,
    output logic read_refused_o,
    output logic [$clog2(DEPTH):0] fill_level_o
);
    import dcf_pkg::*;

    // ==========================================================
    // sizes
    // depth must be a power of two so the pointers wrap by themselves
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam int CMP_W = DCF_OFS_W + 2;
    localparam logic [CW-1:0] DEPTH_CNT = CW'(DEPTH);
    localparam logic [CMP_W-1:0] DEPTH_CMP = CMP_W'(DEPTH);
    localparam logic [CW-1:0] ONE_CNT = CW'(1);
    localparam logic [AW-1:0] ONE_PTR = AW'(1);

    // ==========================================================
    // reset release
    // the synchroniser runs even with the clock enable low,
    // otherwise a frozen block could never leave reset
    logic rst_meta_q;
    logic rst_sync_n_q;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_n_q <= rst_meta_q;
        end
    end

    // ==========================================================
    // state
    dcf_mode_t mode_q;
    dcf_ofs_sel_t sel_q;
    dcf_ofs_sel_t sel_d;
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic [DCF_OFS_W-1:0] empty_ofs_q;
    logic [DCF_OFS_W-1:0] full_ofs_q;
    logic [DCF_DATA_W-1:0] read_data_q;
    logic full_n_q;
    logic empty_n_q;
    logic almost_full_n_q;
    logic almost_empty_n_q;
    logic write_refused_q;
    logic read_refused_q;
    logic [DCF_DATA_W-1:0] store_word;

    // ==========================================================
    // request decode
    logic fifo_rst;
    logic load_active;
    logic wr_req;
    logic rd_req;
    logic is_full;
    logic is_empty;
    logic wr_fifo;
    logic rd_fifo;
    logic ofs_wr;
    logic ofs_rd;

    assign fifo_rst = !fifo_reset_n_i;
    assign is_full = (count_q == DEPTH_CNT);
    assign is_empty = (count_q == '0);

    // low load pin steers both ports to the offset registers
    assign load_active = (mode_q == dcf_mode_prog_flags) && !write_enable_second_or_load_i;

    // same pin term in both modes: second enable high, or load released
    assign wr_req = !write_enable_primary_n_i && write_enable_second_or_load_i;
    assign rd_req = !read_enable_a_n_i && !read_enable_b_n_i;

    assign wr_fifo = !fifo_rst && wr_req && !is_full;
    assign rd_fifo = !fifo_rst && rd_req && !load_active && !is_empty;
    assign ofs_wr = !fifo_rst && load_active && !write_enable_primary_n_i;
    // a simultaneous offset write wins; the readback is dropped at that edge
    assign ofs_rd = !fifo_rst && load_active && rd_req && !ofs_wr;

    // ==========================================================
    // configuration strap
    always_ff @(posedge mclk_i or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            mode_q <= DCF_MODE_RESET;
        end
        else if (ce_i && fifo_rst)
        begin
            if (write_enable_second_or_load_i)
            begin
                mode_q <= dcf_mode_dual_enable;
            end
            else
            begin
                mode_q <= dcf_mode_prog_flags;
            end
        end
    end

    // ==========================================================
    // storage
    dcf_store #(
        .WIDTH(DCF_DATA_W),
        .DEPTH(DEPTH)
    ) u_store (
        .mclk_i(mclk_i),
        .write_i(ce_i && wr_fifo),
        .write_index_i(wr_ptr_q),
        .write_word_i(write_data_i),
        .read_index_i(rd_ptr_q),
        .read_word_o(store_word)
    );

    // ==========================================================
    // pointers
    always_ff @(posedge mclk_i or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end
        else if (ce_i)
        begin
            if (fifo_rst)
            begin
                wr_ptr_q <= '0;
                rd_ptr_q <= '0;
            end
            else
            begin
                if (wr_fifo)
                begin
                    wr_ptr_q <= wr_ptr_q + ONE_PTR;
                end
                if (rd_fifo)
                begin
                    rd_ptr_q <= rd_ptr_q + ONE_PTR;
                end
            end
        end
    end

    // ==========================================================
    // fill level
    // one clock for both ports, so the level is exact each cycle
    // and needs no pointer crossing
    always_comb
    begin
        count_d = count_q;
        unique case ({wr_fifo, rd_fifo})
            2'b10: count_d = count_q + ONE_CNT;
            2'b01: count_d = count_q - ONE_CNT;
            default: count_d = count_q;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            count_q <= '0;
        end
        else if (ce_i)
        begin
            if (fifo_rst)
            begin
                count_q <= '0;
            end
            else
            begin
                count_q <= count_d;
            end
        end
    end

    // ==========================================================
    // flags
    logic [CMP_W-1:0] level_cmp;
    logic [CMP_W-1:0] empty_ofs_cmp;
    logic [CMP_W-1:0] full_ofs_cmp;

    assign level_cmp = CMP_W'(count_d);
    assign empty_ofs_cmp = CMP_W'(empty_ofs_q);
    assign full_ofs_cmp = CMP_W'(full_ofs_q);

    // flags are registers fed from the next level, never from
    // combinational pointer compares at the pins
    always_ff @(posedge mclk_i or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            full_n_q <= 1'b1;
            almost_full_n_q <= 1'b1;
            empty_n_q <= 1'b0;
            almost_empty_n_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (fifo_rst)
            begin
                full_n_q <= 1'b1;
                almost_full_n_q <= 1'b1;
                empty_n_q <= 1'b0;
                almost_empty_n_q <= 1'b0;
            end
            else
            begin
                full_n_q <= (count_d != DEPTH_CNT);
                almost_full_n_q <= ((level_cmp + full_ofs_cmp) < DEPTH_CMP);
                empty_n_q <= (count_d != '0);
                almost_empty_n_q <= (level_cmp > empty_ofs_cmp);
            end
        end
    end

    // ==========================================================
    // offset byte selector
    always_comb
    begin
        sel_d = sel_q;
        unique case (sel_q)
            dcf_sel_empty_lo: sel_d = dcf_sel_empty_hi;
            dcf_sel_empty_hi: sel_d = dcf_sel_full_lo;
            dcf_sel_full_lo: sel_d = dcf_sel_full_hi;
            dcf_sel_full_hi: sel_d = dcf_sel_empty_lo;
        endcase
    end

    // leaving load mode keeps the selector, so a partial load resumes
    always_ff @(posedge mclk_i or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            sel_q <= DCF_SEL_RESET;
        end
        else if (ce_i)
        begin
            if (fifo_rst)
            begin
                sel_q <= DCF_SEL_RESET;
            end
            else if (ofs_wr || ofs_rd)
            begin
                sel_q <= sel_d;
            end
        end
    end

    // ==========================================================
    // offset registers
    logic [DCF_OFS_BYTE_W-1:0] load_byte;

    assign load_byte = write_data_i[DCF_OFS_BYTE_W-1:0];

    always_ff @(posedge mclk_i or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            empty_ofs_q <= DCF_OFS_RESET;
            full_ofs_q <= DCF_OFS_RESET;
        end
        else if (ce_i)
        begin
            if (fifo_rst)
            begin
                empty_ofs_q <= DCF_OFS_RESET;
                full_ofs_q <= DCF_OFS_RESET;
            end
            else if (ofs_wr)
            begin
                unique case (sel_q)
                    dcf_sel_empty_lo:
                        empty_ofs_q[DCF_OFS_LO_LSB +: DCF_OFS_BYTE_W] <= load_byte;
                    dcf_sel_empty_hi:
                        empty_ofs_q[DCF_OFS_HI_LSB +: DCF_OFS_BYTE_W] <= load_byte;
                    dcf_sel_full_lo:
                        full_ofs_q[DCF_OFS_LO_LSB +: DCF_OFS_BYTE_W] <= load_byte;
                    dcf_sel_full_hi:
                        full_ofs_q[DCF_OFS_HI_LSB +: DCF_OFS_BYTE_W] <= load_byte;
                endcase
            end
        end
    end

    // ==========================================================
    // output register
    logic [DCF_OFS_BYTE_W-1:0] readback_byte;

    always_comb
    begin
        readback_byte = '0;
        unique case (sel_q)
            dcf_sel_empty_lo: readback_byte = empty_ofs_q[DCF_OFS_LO_LSB +: DCF_OFS_BYTE_W];
            dcf_sel_empty_hi: readback_byte = empty_ofs_q[DCF_OFS_HI_LSB +: DCF_OFS_BYTE_W];
            dcf_sel_full_lo: readback_byte = full_ofs_q[DCF_OFS_LO_LSB +: DCF_OFS_BYTE_W];
            dcf_sel_full_hi: readback_byte = full_ofs_q[DCF_OFS_HI_LSB +: DCF_OFS_BYTE_W];
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            read_data_q <= DCF_DOUT_RESET;
        end
        else if (ce_i)
        begin
            if (fifo_rst)
            begin
                read_data_q <= DCF_DOUT_RESET;
            end
            else if (rd_fifo)
            begin
                read_data_q <= store_word;
            end
            else if (ofs_rd)
            begin
                read_data_q <= {1'b0, readback_byte};
            end
        end
    end

    // ==========================================================
    // refused access pulses
    // a write into a full fifo or a read from an empty one is
    // dropped; these pulses let the system see the lost beat
    always_ff @(posedge mclk_i or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            write_refused_q <= 1'b0;
            read_refused_q <= 1'b0;
        end
        else if (ce_i)
        begin
            write_refused_q <= !fifo_rst && wr_req && is_full;
            read_refused_q <= !fifo_rst && rd_req && !load_active && is_empty;
        end
    end

    // ==========================================================
    // outputs
    assign read_data_o = read_data_q;
    assign full_flag_n_o = full_n_q;
    assign empty_flag_n_o = empty_n_q;
    assign almost_full_flag_n_o = almost_full_n_q;
    assign almost_empty_flag_n_o = almost_empty_n_q;
    assign dual_enable_mode_o = (mode_q == dcf_mode_dual_enable);
    assign write_refused_o = write_refused_q;
    assign read_refused_o = read_refused_q;
    assign fill_level_o = count_q;

endmodule // dcf_fifo

// ===== dcf_pkg.sv
// constants, field layouts and types shared by the fifo files
package dcf_pkg;

    // ==========================================================
    // data path
    localparam int DCF_DATA_W = 9;
    localparam int DCF_DEPTH_DEF = 64;
    localparam logic [8:0] DCF_DOUT_RESET = 9'h000;

    // ==========================================================
    // flag offset registers: two bytes each
    localparam int DCF_OFS_BYTE_W = 8;
    localparam int DCF_OFS_W = 16;
    localparam int DCF_OFS_LO_LSB = 0;
    localparam int DCF_OFS_HI_LSB = 8;
    localparam logic [15:0] DCF_OFS_RESET = 16'h0007;

    // ==========================================================
    // offset byte selector, advanced by each load or readback
    typedef enum logic [1:0]
    {
        dcf_sel_empty_lo,
        dcf_sel_empty_hi,
        dcf_sel_full_lo,
        dcf_sel_full_hi
    } dcf_ofs_sel_t;

    localparam dcf_ofs_sel_t DCF_SEL_RESET = dcf_sel_empty_lo;

    // ==========================================================
    // configuration caught while the fifo reset is low
    typedef enum logic
    {
        dcf_mode_prog_flags,
        dcf_mode_dual_enable
    } dcf_mode_t;

    localparam dcf_mode_t DCF_MODE_RESET = dcf_mode_prog_flags;

endpackage

// ===== dcf_store.sv
// flip-flop storage array of the fifo, one write port and one read index
`timescale 1ns/100ps

module dcf_store #(
    parameter int WIDTH = dcf_pkg::DCF_DATA_W,
    parameter int DEPTH = dcf_pkg::DCF_DEPTH_DEF
) (
    // clock
    input wire logic mclk_i,
    // write port
    input wire logic write_i,
    input wire logic [$clog2(DEPTH)-1:0] write_index_i,
    input wire logic [WIDTH-1:0] write_word_i,
    // read port
    input wire logic [$clog2(DEPTH)-1:0] read_index_i,
    output logic [WIDTH-1:0] read_word_o
);
    import dcf_pkg::*;

    // ==========================================================
    // storage
    // no reset: contents are only read behind a valid write
    logic [WIDTH-1:0] cell_q [DEPTH];

    always_ff @(posedge mclk_i)
    begin
        if (write_i)
        begin
            cell_q[write_index_i] <= write_word_i;
        end
    end

    assign read_word_o = cell_q[read_index_i];

endmodule // dcf_store

// ===== dcf_peer.sv
// writing and reading system logic that drives the fifo pins
`timescale 1ns/100ps

module dcf_peer (
    // clock
    input wire logic mclk_i,
    // fifo pins
    output logic ce_o,
    output logic fifo_reset_n_o,
    output logic write_enable_primary_n_o,
    output logic write_enable_second_or_load_o,
    output logic read_enable_a_n_o,
    output logic read_enable_b_n_o,
    output logic [dcf_pkg::DCF_DATA_W-1:0] write_data_o
);
    import dcf_pkg::*;

    logic was_reset = 1'b0;

    initial
    begin
        ce_o = 1'b1;
        fifo_reset_n_o = 1'b0;
        write_enable_primary_n_o = 1'b1;
        write_enable_second_or_load_o = 1'b0;
        read_enable_a_n_o = 1'b1;
        read_enable_b_n_o = 1'b1;
        write_data_o = 9'h000;
    end

    // ==========================================================
    // one clock of pin activity, changed just after an edge
    task automatic op(input logic rs_n, input logic pn, input logic sl,
        input logic ra, input logic rb, input logic [DCF_DATA_W-1:0] d);
        fifo_reset_n_o <= rs_n;
        write_enable_primary_n_o <= pn || !was_reset;
        write_enable_second_or_load_o <= sl;
        read_enable_a_n_o <= ra;
        read_enable_b_n_o <= rb;
        // idle bus flips, so a stale word is never mistaken for data
        write_data_o <= pn ? ~write_data_o : d;
        if (!rs_n)
            was_reset = 1'b1;
        @(posedge mclk_i);
        #1;
    endtask

    // clock enable for the fifo, changed just after an edge
    task automatic hold_ce(input logic en);
        ce_o <= en;
    endtask
endmodule // dcf_peer

// ===== dcf_fifo_assertions.sv
// concurrent checks on the fifo top ports
`timescale 1ns/100ps

module dcf_fifo_assertions #(
    parameter int DEPTH = 16
) (
    // clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // fifo control pins
    input wire logic fifo_reset_n_i,
    input wire logic write_enable_primary_n_i,
    input wire logic write_enable_second_or_load_i,
    input wire logic read_enable_a_n_i,
    input wire logic read_enable_b_n_i,
    // outputs
    input wire logic [dcf_pkg::DCF_DATA_W-1:0] read_data_o,
    input wire logic full_flag_n_o,
    input wire logic empty_flag_n_o,
    input wire logic almost_full_flag_n_o,
    input wire logic almost_empty_flag_n_o,
    input wire logic dual_enable_mode_o,
    input wire logic write_refused_o,
    input wire logic read_refused_o,
    input wire logic [$clog2(DEPTH):0] fill_level_o
);
    import dcf_pkg::*;

    // ==========================================================
    // helpers
    logic [1:0] up_q;
    logic go, rd_try, wr_ok, rd_ok;
    // internal reset lingers two edges after release
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    end
    assign go = ce_i && fifo_reset_n_i && up_q == 2'h3;
    assign rd_try = go && !read_enable_a_n_i && !read_enable_b_n_i
        && (dual_enable_mode_o || write_enable_second_or_load_i);
    assign wr_ok = go && !write_enable_primary_n_i && write_enable_second_or_load_i
        && full_flag_n_o;
    assign rd_ok = rd_try && empty_flag_n_o;

    // ==========================================================
    // properties
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence write_only_s;
        wr_ok && !rd_ok;
    endsequence
    sequence read_only_s;
        rd_ok && !wr_ok;
    endsequence

    reset_state_a: assert property (!fifo_reset_n_i && ce_i |=> full_flag_n_o
        && almost_full_flag_n_o && !empty_flag_n_o && !almost_empty_flag_n_o
        && read_data_o == DCF_DOUT_RESET && fill_level_o == '0)
        else $error("fifo reset state wrong");
    write_count_a: assert property (write_only_s |=>
        fill_level_o == $past(fill_level_o) + 1'b1)
        else $error("accepted write did not add one word");
    read_count_a: assert property (read_only_s |=>
        fill_level_o == $past(fill_level_o) - 1'b1)
        else $error("accepted read did not remove one word");
    full_flag_a: assert property (full_flag_n_o == (fill_level_o != DEPTH))
        else $error("full flag disagrees with level");
    empty_flag_a: assert property (empty_flag_n_o == (fill_level_o != 0))
        else $error("empty flag disagrees with level");
    full_refuse_a: assert property (go && !write_enable_primary_n_i
        && write_enable_second_or_load_i && !full_flag_n_o && !rd_try
        |=> write_refused_o && !full_flag_n_o && $stable(fill_level_o))
        else $error("write while full not refused");
    empty_refuse_a: assert property (rd_try && !empty_flag_n_o && !wr_ok
        |=> read_refused_o && $stable(read_data_o))
        else $error("read while empty not refused");
    read_hold_a: assert property (go && (read_enable_a_n_i || read_enable_b_n_i)
        |=> $stable(read_data_o))
        else $error("output changed with a read enable high");
    mode_take_a: assert property (!fifo_reset_n_i && ce_i && up_q == 2'h3
        |=> dual_enable_mode_o == $past(write_enable_second_or_load_i))
        else $error("mode not taken from load pin at reset");
    dual_almost_a: assert property (dual_enable_mode_o |->
        almost_empty_flag_n_o == (fill_level_o > 7)
        && almost_full_flag_n_o == (fill_level_o < DEPTH - 7))
        else $error("default almost flags wrong");
endmodule // dcf_fifo_assertions

bind dcf_fifo dcf_fifo_assertions #(.DEPTH(DEPTH)) u_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .fifo_reset_n_i(fifo_reset_n_i),
    .write_enable_primary_n_i(write_enable_primary_n_i),
    .write_enable_second_or_load_i(write_enable_second_or_load_i),
    .read_enable_a_n_i(read_enable_a_n_i), .read_enable_b_n_i(read_enable_b_n_i),
    .read_data_o(read_data_o), .full_flag_n_o(full_flag_n_o),
    .empty_flag_n_o(empty_flag_n_o), .almost_full_flag_n_o(almost_full_flag_n_o),
    .almost_empty_flag_n_o(almost_empty_flag_n_o),
    .dual_enable_mode_o(dual_enable_mode_o), .write_refused_o(write_refused_o),
    .read_refused_o(read_refused_o), .fill_level_o(fill_level_o)
);

// ===== dcf_fifo_test.sv
// self-checking bench for the fifo in both write enable modes
`timescale 1ns/100ps

module dcf_fifo_test;
    import dcf_pkg::*;

    // ==========================================================
    // signals
    localparam int DEPTH = 16;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce, frst_n, wen_n, wsl, ren_a_n, ren_b_n;
    logic full_n, empty_n, afull_n, aempty_n, dual, wref, rref;
    logic [DCF_DATA_W-1:0] wdata, rdata, w;
    logic [$clog2(DEPTH):0] level;
    logic [DCF_DATA_W-1:0] exp_q[$];
    logic [DCF_DATA_W-1:0] ofs[4] = '{9'h003, 9'h000, 9'h002, 9'h000};
    int n_mismatch = 0;
    int checked = 0;

    always #50 mclk_i = ~mclk_i;

    dcf_peer u_peer (.mclk_i(mclk_i), .ce_o(ce), .fifo_reset_n_o(frst_n),
        .write_enable_primary_n_o(wen_n), .write_enable_second_or_load_o(wsl),
        .read_enable_a_n_o(ren_a_n), .read_enable_b_n_o(ren_b_n), .write_data_o(wdata));

    dcf_fifo #(.DEPTH(DEPTH)) u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .fifo_reset_n_i(frst_n), .write_enable_primary_n_i(wen_n),
        .write_enable_second_or_load_i(wsl), .read_enable_a_n_i(ren_a_n),
        .read_enable_b_n_i(ren_b_n), .write_data_i(wdata), .read_data_o(rdata),
        .full_flag_n_o(full_n), .empty_flag_n_o(empty_n), .almost_full_flag_n_o(afull_n),
        .almost_empty_flag_n_o(aempty_n), .dual_enable_mode_o(dual),
        .write_refused_o(wref), .read_refused_o(rref), .fill_level_o(level));

    // ==========================================================
    // compare and access tasks
    task automatic check_flag(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_val(input string what, input logic [8:0] exp, input logic [8:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic flags(input logic f, input logic af, input logic e, input logic ae);
        check_flag("full", f, full_n);
        check_flag("almost full", af, afull_n);
        check_flag("empty", e, empty_n);
        check_flag("almost empty", ae, aempty_n);
    endtask

    task automatic push(input logic [DCF_DATA_W-1:0] d);
        u_peer.op(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, d);
    endtask

    task automatic pop(input logic [DCF_DATA_W-1:0] exp);
        u_peer.op(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 9'h000);
        check_val("read data", exp, rdata);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ==========================================================
    // tests
    initial
    begin
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
        flags(1'b1, 1'b1, 1'b0, 1'b0);
        check_val("read data", DCF_DOUT_RESET, rdata);
        $display("test power-up done");
        // dual enable mode: fill past full, gate, drain past empty
        u_peer.op(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 9'h000);
        check_flag("mode", 1'b1, dual);
        for (int i = 0; i < DEPTH; i++)
        begin
            w = 9'h155 ^ 9'(i * 37);
            exp_q.push_back(w);
            push(w);
            check_val("level", 9'(i + 1), 9'(level));
            flags(i + 1 < DEPTH, i + 1 < DEPTH - 7, 1'b1, i + 1 > 7);
        end
        push(9'h0AA);
        check_flag("write refused", 1'b1, wref);
        check_val("level", 9'(DEPTH), 9'(level));
        w = exp_q.pop_front();
        pop(w);
        check_flag("full", 1'b1, full_n);
        u_peer.op(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 9'h0AA);
        check_val("level", 9'(DEPTH - 1), 9'(level));
        u_peer.op(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 9'h000);
        check_val("read data", w, rdata);
        check_val("level", 9'(DEPTH - 1), 9'(level));
        w = exp_q.pop_front();
        exp_q.push_back(9'h1C3);
        u_peer.op(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 9'h1C3);
        check_val("read data", w, rdata);
        check_val("level", 9'(DEPTH - 1), 9'(level));
        while (exp_q.size() > 0)
        begin
            w = exp_q.pop_front();
            pop(w);
        end
        flags(1'b1, 1'b1, 1'b0, 1'b0);
        pop(w);
        check_flag("read refused", 1'b1, rref);
        push(9'h011);
        check_flag("empty", 1'b1, empty_n);
        pop(9'h011);
        $display("test dual enable done");
        // programmable flag mode: load offsets, read one back, fill
        u_peer.op(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 9'h000);
        check_flag("mode", 1'b0, dual);
        foreach (ofs[k])
            u_peer.op(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, ofs[k]);
        u_peer.op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 9'h000);
        check_val("empty offset", 9'h003, rdata);
        check_val("level", 9'h000, 9'(level));
        for (int i = 0; i < DEPTH - 1; i++)
        begin
            push(9'(i));
            check_flag("almost empty", i + 1 > 3, aempty_n);
            check_flag("almost full", i + 1 < DEPTH - 2, afull_n);
        end
        // reset in mid-run restores pointers and offsets
        u_peer.op(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 9'h000);
        flags(1'b1, 1'b1, 1'b0, 1'b0);
        check_val("level", 9'h000, 9'(level));
        check_val("read data", DCF_DOUT_RESET, rdata);
        u_peer.op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 9'h000);
        check_val("empty offset", DCF_OFS_RESET[8:0], rdata);
        u_peer.hold_ce(1'b0);
        push(9'h0F0);
        check_val("level frozen", 9'h000, 9'(level));
        u_peer.hold_ce(1'b1);
        push(9'h1E1);
        pop(9'h1E1);
        $display("test programmable flags done");
        finish_test();
    end

    initial
    begin
        #(2000 * 100);
        n_mismatch++;
        finish_test();
    end
endmodule // dcf_fifo_test
